// [src/sac_pkg.sv]
// Constants shared by the converter control block.
// Assumes an 8-bit register port and a single peripheral clock.
package sac_pkg;
    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 3;
    localparam int          DATA_W        = 8;
    localparam logic [2:0]  OFS_CTRL1     = 3'h0;
    localparam logic [2:0]  OFS_CTRL2     = 3'h1;
    localparam logic [2:0]  OFS_RES_HI    = 3'h2;
    localparam logic [2:0]  OFS_RES_LO    = 3'h3;
    localparam logic [2:0]  OFS_IRQ_STS   = 3'h4;
    localparam logic [2:0]  OFS_IRQ_MASK  = 3'h5;
    localparam logic [2:0]  OFS_IRQ_LEVEL = 3'h6;
    // ------------------------------------------------------------
    // First control register fields
    // ------------------------------------------------------------
    localparam int          C1_CH_HI      = 7;
    localparam int          C1_CH_LO      = 4;
    localparam int          C1_DONE       = 3;
    localparam int          C1_BUSY       = 2;
    localparam int          C1_REF        = 1;
    localparam int          C1_START      = 0;
    // ------------------------------------------------------------
    // Second control register fields
    // ------------------------------------------------------------
    localparam int          C2_PREC       = 7;
    localparam int          C2_TIM_HI     = 6;
    localparam int          C2_TIM_LO     = 5;
    localparam int          C2_TSEL       = 4;
    localparam int          C2_IE         = 3;
    localparam int          C2_EXT        = 2;
    localparam int          C2_CK_HI      = 1;
    localparam int          C2_CK_LO      = 0;
    // ------------------------------------------------------------
    // Interrupt status bits, level and vector
    // ------------------------------------------------------------
    localparam int          IRQ_W         = 2;
    localparam int          IRQ_DONE      = 0;
    localparam int          IRQ_RESTART   = 1;
    localparam int          LVL_W         = 2;
    localparam logic [1:0]  LVL_RESET     = 2'h3;
    localparam logic [4:0]  IRQ_NUMBER    = 5'h12;
    localparam logic [15:0] IRQ_VECTOR    = 16'hFFD6;
    // ------------------------------------------------------------
    // Conversion sizing
    // ------------------------------------------------------------
    localparam int          RES_W         = 10;
    localparam int          RES8_LSB      = 2;
    localparam int          CH_COUNT      = 8;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    typedef enum logic [1:0] {
        SAC_IDLE    = 2'b00,
        SAC_SAMPLE  = 2'b01,
        SAC_COMPARE = 2'b10
    } sac_state_t;
endpackage

// [src/sac_conv_ctrl.sv]
// Control logic of an 8/10-bit successive approximation converter.
// Assumes the comparator answers within one conversion clock tick and
// that all inputs are synchronous to i_clk_sys.

module sac_conv_ctrl
    import sac_pkg::*;
#(
    parameter int DIV_BASE    = 2,
    parameter int SAMPLE_UNIT = 4
)(
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_reset_n,
    input  wire logic [sac_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [sac_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    input  wire logic                     i_halt,
    input  wire logic                     i_timer_out,
    input  wire logic                     i_cmp_high,
    output logic [sac_pkg::DATA_W-1:0]    o_rdata,
    output logic                          o_irq,
    output logic [sac_pkg::LVL_W-1:0]     o_irq_level,
    output logic [4:0]                    o_irq_number,
    output logic [15:0]                   o_irq_vector,
    output logic                          o_ref_supply_on,
    output logic                          o_sample_hold,
    output logic                          o_channel_en,
    output logic [2:0]                    o_channel,
    output logic [sac_pkg::RES_W-1:0]     o_trial_code
);
    import sac_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] div_last(input logic [1:0] sel);
        div_last = 8'((DIV_BASE << sel) - 1);
    endfunction

    function automatic logic [7:0] sample_ticks(input logic [1:0] sel);
        sample_ticks = 8'(SAMPLE_UNIT * (int'(sel) + 1));
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    logic [3:0]           chan_q;
    logic                 done_q;
    logic                 busy_q;
    logic                 ref_q;
    logic                 prec8_q;
    logic [1:0]           tim_q;
    logic                 tsel_q;
    logic                 ie_q;
    logic                 ext_q;
    logic [1:0]           ck_q;
    logic [LVL_W-1:0]     lvl_q;
    logic [IRQ_W-1:0]     sts_q;
    logic [IRQ_W-1:0]     mask_q;
    logic [RES_W-1:0]     result_q;
    logic                 timer_prev_q;
    sac_state_t           state_q;
    logic [7:0]           div_q;
    logic [7:0]           phase_q;
    logic [3:0]           bit_q;
    logic [RES_W-1:0]     trial_q;

    logic                 wr_c1;
    logic                 sw_start;
    logic                 hw_start;
    logic                 start;
    logic                 tick;
    logic                 finish;
    logic [3:0]           last_bit;
    logic [RES_W-1:0]     settled;

    assign wr_c1    = i_wr && hit(i_addr, OFS_CTRL1);
    assign sw_start = wr_c1 && i_wdata[C1_START];
    assign hw_start = ext_q && tsel_q && i_timer_out && !timer_prev_q;
    assign start    = (sw_start || hw_start) && !i_halt;
    assign tick     = (div_q == div_last(ck_q));
    assign last_bit = prec8_q ? 4'(RES8_LSB) : 4'h0;
    // a restart does not hide completion
    assign finish   = (state_q == SAC_COMPARE) && tick && (bit_q == last_bit)
                      && !i_halt;
    assign settled  = i_cmp_high ? trial_q : (trial_q & ~(RES_W'(1) << bit_q));

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            chan_q  <= 4'h0;
            ref_q   <= 1'b0;
            prec8_q <= 1'b0;
            tim_q   <= 2'h0;
            tsel_q  <= 1'b0;
            ie_q    <= 1'b0;
            ext_q   <= 1'b0;
            ck_q    <= 2'h0;
            lvl_q   <= LVL_RESET;
            mask_q  <= '0;
        end
        else if (i_wr)
        begin
            if (hit(i_addr, OFS_CTRL1))
            begin
                chan_q <= i_wdata[C1_CH_HI:C1_CH_LO];
                ref_q  <= i_wdata[C1_REF];
            end
            else if (hit(i_addr, OFS_CTRL2))
            begin
                prec8_q <= i_wdata[C2_PREC];
                tim_q   <= i_wdata[C2_TIM_HI:C2_TIM_LO];
                tsel_q  <= i_wdata[C2_TSEL];
                ie_q    <= i_wdata[C2_IE];
                ext_q   <= i_wdata[C2_EXT];
                ck_q    <= i_wdata[C2_CK_HI:C2_CK_LO];
            end
            else if (hit(i_addr, OFS_IRQ_MASK))
            begin
                mask_q <= i_wdata[IRQ_W-1:0];
            end
            else if (hit(i_addr, OFS_IRQ_LEVEL))
            begin
                lvl_q <= i_wdata[LVL_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Done flag and interrupt status
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            done_q   <= 1'b0;
            result_q <= '0;
        end
        else if (finish)
        begin
            done_q   <= 1'b1;
            result_q <= prec8_q ? (settled >> RES8_LSB) : settled;
        end
        else if (start)
        begin
            done_q <= 1'b0;
        end
        else if (wr_c1 && !i_wdata[C1_DONE])
        begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sts_q <= '0;
        end
        else
        begin
            for (int i = 0; i < IRQ_W; i++)
            begin
                if ((i == IRQ_DONE && finish) ||
                    (i == IRQ_RESTART && start && busy_q))
                begin
                    sts_q[i] <= 1'b1;
                end
                else if (i_wr && hit(i_addr, OFS_IRQ_STS) && i_wdata[i])
                begin
                    sts_q[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            timer_prev_q <= 1'b0;
        end
        else
        begin
            timer_prev_q <= i_timer_out;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            div_q <= 8'h00;
        end
        else if (start || tick || state_q == SAC_IDLE)
        begin
            div_q <= 8'h00;
        end
        else
        begin
            div_q <= div_q + 8'h01;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_q  <= SAC_IDLE;
            busy_q   <= 1'b0;
            phase_q  <= 8'h00;
            bit_q    <= 4'h0;
            trial_q  <= '0;
        end
        else if (i_halt)
        begin
            state_q <= SAC_IDLE;
            busy_q  <= 1'b0;
        end
        // busy set at start, restart allowed
        else if (start)
        begin
            state_q <= SAC_SAMPLE;
            busy_q  <= 1'b1;
            phase_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                SAC_SAMPLE:
                begin
                    if (tick)
                    begin
                        phase_q <= phase_q + 8'h01;
                        if (phase_q + 8'h01 == sample_ticks(tim_q))
                        begin
                            state_q <= SAC_COMPARE;
                            bit_q   <= 4'(RES_W - 1);
                            trial_q <= RES_W'(1) << (RES_W - 1);
                        end
                    end
                end
                SAC_COMPARE:
                begin
                    if (tick)
                    begin
                        if (!i_cmp_high)
                        begin
                            trial_q[bit_q] <= 1'b0;
                        end
                        if (bit_q == last_bit)
                        begin
                            state_q <= SAC_IDLE;
                            busy_q  <= 1'b0;
                        end
                        else
                        begin
                            bit_q              <= bit_q - 4'h1;
                            trial_q[bit_q - 1] <= 1'b1;
                        end
                    end
                end
                default:
                begin
                    state_q <= SAC_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port and outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_rdata <= REG_RESET;
        end
        else if (!i_rd)
        begin
            o_rdata <= REG_RESET;
        end
        else if (hit(i_addr, OFS_CTRL1))
        begin
            o_rdata <= {chan_q, done_q, busy_q, ref_q, 1'b0};
        end
        else if (hit(i_addr, OFS_CTRL2))
        begin
            o_rdata <= {prec8_q, tim_q, tsel_q, ie_q, ext_q, ck_q};
        end
        else if (hit(i_addr, OFS_RES_HI))
        begin
            o_rdata <= {6'h00, result_q[RES_W-1:DATA_W]};
        end
        else if (hit(i_addr, OFS_RES_LO))
        begin
            o_rdata <= result_q[DATA_W-1:0];
        end
        else if (hit(i_addr, OFS_IRQ_STS))
        begin
            o_rdata <= {6'h00, sts_q};
        end
        else if (hit(i_addr, OFS_IRQ_MASK))
        begin
            o_rdata <= {6'h00, mask_q};
        end
        else if (hit(i_addr, OFS_IRQ_LEVEL))
        begin
            o_rdata <= {6'h00, lvl_q};
        end
        else
        begin
            o_rdata <= REG_RESET;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_irq           <= 1'b0;
            o_irq_level     <= LVL_RESET;
            o_irq_number    <= IRQ_NUMBER;
            o_irq_vector    <= IRQ_VECTOR;
            o_ref_supply_on <= 1'b0;
            o_sample_hold   <= 1'b0;
            o_channel_en    <= 1'b0;
            o_channel       <= 3'h0;
            o_trial_code    <= '0;
        end
        else
        begin
            o_irq           <= (done_q && ie_q) || |(sts_q & mask_q);
            o_irq_level     <= lvl_q;
            o_irq_number    <= IRQ_NUMBER;
            o_irq_vector    <= IRQ_VECTOR;
            o_ref_supply_on <= ref_q;
            o_sample_hold   <= (state_q == SAC_SAMPLE);
            o_channel_en    <= busy_q && (chan_q < 4'(CH_COUNT));
            o_channel       <= chan_q[2:0];
            o_trial_code    <= trial_q;
        end
    end
endmodule

// [verification/sac_conv_ctrl_properties.sv]
// Port-level checker for the converter control block.
// Assumes it is bound to sac_conv_ctrl and shadows a few control writes.
module sac_conv_ctrl_properties
    import sac_pkg::*;
#(
    parameter int DIV_BASE    = 2,
    parameter int SAMPLE_UNIT = 4
)(
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_reset_n,
    input  wire logic [sac_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [sac_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    input  wire logic                       i_halt,
    input  wire logic                       i_timer_out,
    input  wire logic                       i_cmp_high,
    input  wire logic [sac_pkg::DATA_W-1:0] o_rdata,
    input  wire logic                       o_irq,
    input  wire logic [sac_pkg::LVL_W-1:0]  o_irq_level,
    input  wire logic [4:0]                 o_irq_number,
    input  wire logic [15:0]                o_irq_vector,
    input  wire logic                       o_ref_supply_on,
    input  wire logic                       o_sample_hold,
    input  wire logic                       o_channel_en,
    input  wire logic [2:0]                 o_channel,
    input  wire logic [sac_pkg::RES_W-1:0]  o_trial_code
);
    logic [3:0]       chan_q;
    logic [IRQ_W-1:0] mask_q;
    logic             ie_q;
    logic             ext_q;
    logic             tsel_q;

    // --------------------------------------------------------
    // Shadow of software settings
    // --------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            chan_q <= '0;
            mask_q <= '0;
            ie_q   <= 1'b0;
            ext_q  <= 1'b0;
            tsel_q <= 1'b0;
        end
        else if (i_wr)
        begin
            if (i_addr == OFS_CTRL1)
                chan_q <= i_wdata[C1_CH_HI:C1_CH_LO];
            if (i_addr == OFS_IRQ_MASK)
                mask_q <= i_wdata[IRQ_W-1:0];
            if (i_addr == OFS_CTRL2)
            begin
                ie_q   <= i_wdata[C2_IE];
                ext_q  <= i_wdata[C2_EXT];
                tsel_q <= i_wdata[C2_TSEL];
            end
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    property p_vector;
        o_irq_number == IRQ_NUMBER && o_irq_vector == IRQ_VECTOR;
    endproperty
    property p_ref;
        i_wr && i_addr == OFS_CTRL1 |-> ##2 o_ref_supply_on == $past(i_wdata[C1_REF], 2);
    endproperty
    property p_sw_start;
        i_wr && i_addr == OFS_CTRL1 && i_wdata[C1_START] && !i_wdata[C1_CH_HI] && !i_halt
            |-> ##[1:3] (o_sample_hold && o_channel_en);
    endproperty
    property p_tmr_start;
        ext_q && tsel_q && !chan_q[3] && !i_halt && $rose(i_timer_out) |-> ##[1:4] o_sample_hold;
    endproperty
    property p_irq_off;
        (!ie_q && mask_q == '0) [*2] |-> !o_irq;
    endproperty
    property p_halt;
        i_halt [*2] |=> !o_channel_en && !o_sample_hold;
    endproperty
    property p_channel;
        o_sample_hold |-> o_channel_en == !chan_q[3] && o_channel == chan_q[2:0];
    endproperty
    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == '0;
    endproperty
    property p_sample_first;
        $rose(o_channel_en) |-> ##[0:2] o_sample_hold;
    endproperty

    a_vector: assert property (p_vector) else $error("irq number or vector wrong");
    a_ref: assert property (p_ref) else $error("reference switch mismatch");
    a_sw_start: assert property (p_sw_start) else $error("software start ignored");
    a_tmr_start: assert property (p_tmr_start) else $error("timer edge ignored");
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    a_halt: assert property (p_halt) else $error("halt did not stop");
    a_channel: assert property (p_channel) else $error("wrong pin sampled");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    a_sample_first: assert property (p_sample_first) else $error("no sampling phase");

    c_irq: cover property ($rose(o_irq));
    c_halt: cover property (i_halt && o_channel_en);
    c_tmr: cover property (ext_q && tsel_q && $rose(o_sample_hold));
endmodule

// [verification/sac_cmp_model.sv]
// Behavioural sample-and-hold and comparator facing the control block.
// Assumes one fixed analog level per input pin.
module sac_cmp_model
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset_n,
    input  wire logic [9:0] i_trial_code,
    input  wire logic [2:0] i_channel,
    input  wire logic       i_channel_en,
    input  wire logic       i_sample_hold,
    output logic            o_cmp_high
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] LEVELS [8] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA,
                                          10'h001, 10'h200, 10'h1FF, 10'h37C};
    logic [9:0] held_q;
    logic       idle_q;

    // Capacitor holds the level; idle output wanders
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            held_q <= 10'h000;
            idle_q <= 1'b0;
        end
        else
        begin
            idle_q <= ~idle_q;
            if (i_sample_hold && i_channel_en)
                held_q <= LEVELS[i_channel];
        end
    end

    assign o_cmp_high = i_channel_en ? (held_q >= i_trial_code) : idle_q;
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the converter control block.
// Assumes the comparator model and the property checker are compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sac_pkg::*;
    typedef struct packed {
        logic [3:0] ch;
        logic [7:0] c2;
        logic [7:0] hi;
        logic [7:0] lo;
    } sac_tb_row_t;
    localparam sac_tb_row_t ROWS [8] = '{
        '{4'h0, 8'h00, 8'h00, 8'h00}, '{4'h1, 8'h21, 8'h03, 8'hFF},
        '{4'h2, 8'h42, 8'h01, 8'h55}, '{4'h3, 8'h83, 8'h00, 8'hAA},
        '{4'h4, 8'h60, 8'h00, 8'h01}, '{4'h5, 8'hE1, 8'h00, 8'h80},
        '{4'h6, 8'h00, 8'h01, 8'hFF}, '{4'h7, 8'h80, 8'h00, 8'hDF}};
    logic        i_clk_sys, i_reset_n, i_wr, i_rd, i_halt, i_timer_out, i_cmp_high;
    logic [2:0]  i_addr, o_channel;
    logic [7:0]  i_wdata, o_rdata;
    logic [1:0]  o_irq_level;
    logic [4:0]  o_irq_number;
    logic [15:0] o_irq_vector;
    logic [9:0]  o_trial_code;
    logic        o_irq, o_ref_supply_on, o_sample_hold, o_channel_en;
    int          error_cnt = 0;
    int          cmp_count = 0;

    sac_conv_ctrl #(.DIV_BASE(2), .SAMPLE_UNIT(1)) u_dut (.i_clk_sys, .i_reset_n, .i_addr,
        .i_wdata, .i_wr, .i_rd, .i_halt, .i_timer_out, .i_cmp_high, .o_rdata, .o_irq,
        .o_irq_level, .o_irq_number, .o_irq_vector, .o_ref_supply_on, .o_sample_hold,
        .o_channel_en, .o_channel, .o_trial_code);
    sac_cmp_model u_cmp (.i_clk_sys, .i_reset_n, .i_trial_code(o_trial_code),
        .i_channel(o_channel), .i_channel_en(o_channel_en), .i_sample_hold(o_sample_hold),
        .o_cmp_high(i_cmp_high));

    initial
    begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        chk_byte(o_rdata, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic wait_idle;
        int i;
        for (i = 0; i < 300; i++)
        begin
            @(posedge i_clk_sys);
            i_rd <= 1'b1;
            i_addr <= OFS_CTRL1;
            @(posedge i_clk_sys);
            i_rd <= 1'b0;
            #1;
            if (o_rdata[C1_BUSY] === 1'b0)
                break;
        end
        chk_bit(o_rdata[C1_BUSY], 1'b0);
    endtask
    task automatic timer_pulse;
        @(posedge i_clk_sys);
        i_timer_out <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        i_timer_out <= 1'b0;
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #200000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial
    begin
        {i_reset_n, i_wr, i_rd, i_halt, i_timer_out} = '0;
        i_addr = 3'h0;
        i_wdata = 8'h00;
        repeat (16) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        rchk(OFS_CTRL1, 8'h00);
        rchk(OFS_IRQ_LEVEL, 8'h03);
        chk_byte({3'h0, o_irq_number}, 8'h12);
        chk_byte(o_irq_vector[15:8], 8'hFF);
        chk_byte(o_irq_vector[7:0], 8'hD6);
        wr(OFS_IRQ_LEVEL, 8'h01);
        settle(1);
        chk_byte({6'h0, o_irq_level}, 8'h01);
        wr(3'h7, 8'hFF);
        rchk(3'h7, 8'h00);
        foreach (ROWS[k])
        begin
            wr(OFS_CTRL2, ROWS[k].c2);
            wr(OFS_CTRL1, {ROWS[k].ch, 4'hB});
            rchk(OFS_CTRL1, {ROWS[k].ch, 4'h6});
            chk_byte({o_channel_en, o_channel}, {1'b1, ROWS[k].ch[2:0]});
            wait_idle();
            rchk(OFS_CTRL1, {ROWS[k].ch, 4'hA});
            rchk(OFS_RES_HI, ROWS[k].hi);
            rchk(OFS_RES_LO, ROWS[k].lo);
        end
        chk_bit(o_ref_supply_on, 1'b1);
        wr(OFS_CTRL1, 8'h00);
        settle(1);
        chk_bit(o_ref_supply_on, 1'b0);
        // Completion interrupt, enable and clearing
        wr(OFS_CTRL2, 8'h08);
        wr(OFS_CTRL1, 8'h2B);
        wait_idle();
        settle(2);
        chk_bit(o_irq, 1'b1);
        wr(OFS_CTRL2, 8'h00);
        settle(2);
        chk_bit(o_irq, 1'b0);
        wr(OFS_CTRL2, 8'h08);
        settle(2);
        chk_bit(o_irq, 1'b1);
        wr(OFS_CTRL1, 8'h22);
        rchk(OFS_CTRL1, 8'h22);
        chk_bit(o_irq, 1'b0);
        rchk(OFS_IRQ_STS, 8'h01);
        wr(OFS_IRQ_MASK, 8'h01);
        settle(2);
        chk_bit(o_irq, 1'b1);
        wr(OFS_IRQ_STS, 8'h01);
        settle(2);
        chk_bit(o_irq, 1'b0);
        // Restart during a slow conversion
        wr(OFS_CTRL2, 8'h03);
        wr(OFS_CTRL1, 8'h2B);
        wr(OFS_CTRL1, 8'h2B);
        wait_idle();
        rchk(OFS_IRQ_STS, 8'h03);
        rchk(OFS_RES_LO, 8'h55);
        wr(OFS_IRQ_MASK, 8'h02);
        settle(2);
        chk_bit(o_irq, 1'b1);
        wr(OFS_IRQ_STS, 8'h02);
        rchk(OFS_IRQ_STS, 8'h01);
        chk_bit(o_irq, 1'b0);
        wr(OFS_IRQ_MASK, 8'h00);
        // Restart landing on the last compare tick
        wr(OFS_CTRL2, 8'h00);
        wr(OFS_CTRL1, 8'h2B);
        repeat (20) @(posedge i_clk_sys);
        wr(OFS_CTRL1, 8'h2B);
        rchk(OFS_CTRL1, 8'h2E);
        wait_idle();
        // Timer start source selection
        wr(OFS_CTRL2, 8'h14);
        timer_pulse();
        rchk(OFS_CTRL1, 8'h26);
        wait_idle();
        wr(OFS_CTRL2, 8'h04);
        timer_pulse();
        rchk(OFS_CTRL1, 8'h2A);
        wr(OFS_CTRL2, 8'h10);
        timer_pulse();
        rchk(OFS_CTRL1, 8'h2A);
        // Stop mode and reset abort a conversion
        wr(OFS_CTRL2, 8'h63);
        wr(OFS_CTRL1, 8'h2B);
        repeat (6) @(posedge i_clk_sys);
        i_halt <= 1'b1;
        rchk(OFS_CTRL1, 8'h22);
        wr(OFS_CTRL1, 8'h2B);
        rchk(OFS_CTRL1, 8'h22);
        i_halt <= 1'b0;
        wr(OFS_CTRL1, 8'h2B);
        settle(3);
        i_reset_n <= 1'b0;
        settle(2);
        i_reset_n <= 1'b1;
        rchk(OFS_CTRL1, 8'h00);
        chk_byte({6'h0, o_irq_level}, 8'h03);
        complete_run();
    end
endmodule

bind sac_conv_ctrl sac_conv_ctrl_properties #(.DIV_BASE(DIV_BASE), .SAMPLE_UNIT(SAMPLE_UNIT))
    u_props (.i_clk_sys, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .i_halt, .i_timer_out,
    .i_cmp_high, .o_rdata, .o_irq, .o_irq_level, .o_irq_number, .o_irq_vector,
    .o_ref_supply_on, .o_sample_hold, .o_channel_en, .o_channel, .o_trial_code);
